// >>> rtl/phs_line_sync_gen.sv
// Panel line sync generator with its timing registers on an APB slave port.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module phs_line_sync_gen
(
  // Clock and reset
  input  wire logic                              sys_clk_in,
  input  wire logic                              reset_in,
  // APB slave
  input  wire logic                              psel_in,
  input  wire logic                              penable_in,
  input  wire logic                              pwrite_in,
  input  wire logic [phs_pkg::PHS_ADDR_W-1:0]    paddr_in,
  input  wire logic [phs_pkg::PHS_DATA_W-1:0]    pwdata_in,
  input  wire logic [phs_pkg::PHS_STRB_W-1:0]    pstrb_in,
  output logic [phs_pkg::PHS_DATA_W-1:0]         prdata_out,
  output logic                                   pready_out,
  output logic                                   pslverr_out,
  // Pixel source syncs
  input  wire logic                              source_line_sync_in,
  input  wire logic                              source_frame_sync_in,
  // Panel side
  output logic                                   line_pulse_or_sync_out,
  output logic                                   frame_sync_active_out,
  output logic [phs_pkg::PHS_LCOUNT_W-1:0]       panel_line_count_out
);
  import phs_pkg::*;

  logic [31:0]              timing1_ff;
  logic [31:0]              timing2_ff;
  logic [31:0]              prdata_ff;
  logic [31:0]              nxt_timing1;
  logic [31:0]              nxt_timing2;
  logic [31:0]              rd_data;
  logic [31:0]              status_word;
  logic                     rd_hit;
  logic                     wr_en;
  logic                     line_level;
  logic                     frame_level;
  logic                     line_norm;
  logic                     line_norm_ff;
  logic                     line_rise;
  logic                     line_out_ff;
  logic                     frame_active_ff;
  logic                     frame_pol;
  logic                     line_pol;
  logic                     src;
  logic                     out_pol;
  logic [PHS_LEAD_W-1:0]    lead_code;
  logic [PHS_TRAIL_W-1:0]   trail_code;
  logic [PHS_TRAIL_W-1:0]   lead_pos;
  logic                     edge_pulse;
  logic [PHS_TRAIL_W-1:0]   edge_count;

  // Register fields.
  assign frame_pol  = timing1_ff[PHS_FRAME_POL_BIT];
  assign line_pol   = timing1_ff[PHS_LINE_POL_BIT];
  assign src        = timing1_ff[PHS_SRC_BIT];
  assign lead_code  = timing1_ff[PHS_LEAD_HI:PHS_LEAD_LO];
  assign trail_code = timing1_ff[PHS_TRAIL_HI:PHS_TRAIL_LO];
  assign out_pol    = timing2_ff[PHS_OUT_POL_BIT];

  // Byte-lane merge; reserved bits never store.
  function automatic logic [31:0] merge_lanes
  (
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb,
    input logic [31:0] mask
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < PHS_STRB_W; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res & mask;
  endfunction

  // Address decode and read mux.
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = '0;
    if (paddr_in == PHS_TIMING1_ADDR)
      rd_data = timing1_ff;
    else if (paddr_in == PHS_TIMING2_ADDR)
      rd_data = timing2_ff;
    else if (paddr_in == PHS_STATUS_ADDR)
      rd_data = status_word;
    else
      rd_hit = 1'b0;
  end

  always_comb
  begin
    status_word                                    = '0;
    status_word[PHS_ST_LINE_BIT]                   = line_norm;
    status_word[PHS_ST_FRAME_BIT]                  = frame_active_ff;
    status_word[PHS_ST_PULSE_BIT]                  = edge_pulse;
    status_word[PHS_ST_SRC_BIT]                    = src;
    status_word[PHS_ST_CNT_LO +: PHS_TRAIL_W]      = edge_count;
  end

  assign wr_en = psel_in && penable_in && pwrite_in && rd_hit;

  always_comb
  begin
    nxt_timing1 = timing1_ff;
    nxt_timing2 = timing2_ff;
    if (wr_en && paddr_in == PHS_TIMING1_ADDR)
      nxt_timing1 = merge_lanes(timing1_ff, pwdata_in, pstrb_in, PHS_TIMING1_MASK);
    else if (wr_en && paddr_in == PHS_TIMING2_ADDR)
      nxt_timing2 = merge_lanes(timing2_ff, pwdata_in, pstrb_in, PHS_TIMING2_MASK);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      timing1_ff <= PHS_TIMING1_RESET;
      timing2_ff <= PHS_TIMING2_RESET;
    end
    else
    begin
      timing1_ff <= nxt_timing1;
      timing2_ff <= nxt_timing2;
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      prdata_ff <= '0;
    else if (psel_in && !penable_in && !pwrite_in)
      prdata_ff <= rd_data;
  end

  assign prdata_out  = prdata_ff;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !rd_hit;

  // Input syncs come from another chip, so each is resynchronised first.
  phs_pin_sync u_line_sync
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pin_in     (source_line_sync_in),
    .level_out  (line_level)
  );

  phs_pin_sync u_frame_sync
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .pin_in     (source_frame_sync_in),
    .level_out  (frame_level)
  );

  // Polarity correction makes the sync interval read high internally.
  assign line_norm = line_level ^ line_pol;
  assign line_rise = line_norm && !line_norm_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      line_norm_ff <= 1'b0;
    else
      line_norm_ff <= line_norm;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      frame_active_ff <= 1'b0;
    else
      frame_active_ff <= frame_level ^ frame_pol;
  end

  assign frame_sync_active_out = frame_active_ff;
  assign panel_line_count_out  = timing1_ff[PHS_LCOUNT_HI:PHS_LCOUNT_LO];

  // The edge counter is held cleared unless internal generation is chosen.
  phs_edge_gen #(
    .CNT_W (PHS_TRAIL_W)
  ) u_edge_gen
  (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .enable_in  (src),
    .rise_in    (line_rise),
    .lead_in    (lead_code),
    .trail_in   (trail_code),
    .pulse_out  (edge_pulse),
    .count_out  (edge_count)
  );

  // Pass-through keeps the input level untouched; the internal pulse gets the output polarity.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      line_out_ff <= 1'b0;
    else if (!src)
      line_out_ff <= line_level;
    else
      line_out_ff <= edge_pulse ^ out_pol;
  end

  assign line_pulse_or_sync_out = line_out_ff;

  // Checks.
  assign lead_pos = (lead_code == PHS_LEAD_NO_DELAY) ? '0
                  : PHS_TRAIL_W'(lead_code) + PHS_TRAIL_W'(PHS_LEAD_STEP);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_int_rise;
    src && line_rise;
  endsequence

  sequence s_quiet3;
    (src && !line_rise && $stable(timing1_ff)) [*3];
  endsequence

  property p_frame_pol_low;
    frame_pol && frame_level |=> !frame_sync_active_out;
  endproperty
  a_frame_pol_low: assert property (p_frame_pol_low)
    else $error("Frame sync not inverted for polarity 1.");

  property p_frame_pol_high;
    !frame_pol && frame_level |=> frame_sync_active_out;
  endproperty
  a_frame_pol_high: assert property (p_frame_pol_high)
    else $error("Frame sync not passed for polarity 0.");

  property p_line_rise_pol;
    line_rise |-> (line_level != line_pol) && $past(line_level) == $past(line_pol);
  endproperty
  a_line_rise_pol: assert property (p_line_rise_pol)
    else $error("Line sync rise does not follow the input polarity.");

  property p_out_pol_idle;
    src && !edge_pulse |=> line_pulse_or_sync_out == $past(out_pol);
  endproperty
  a_out_pol_idle: assert property (p_out_pol_idle)
    else $error("Idle output line sync ignores the output polarity.");

  property p_pass_through;
    !src |=> line_pulse_or_sync_out == $past(line_level);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("Pass-through output differs from the input.");

  property p_zero_lead;
    s_int_rise and (lead_code == PHS_LEAD_NO_DELAY && trail_code != '0) |=> edge_pulse;
  endproperty
  a_zero_lead: assert property (p_zero_lead)
    else $error("Zero lead did not start the pulse on the rise.");

  property p_measured_edge;
    src && $stable(line_pol) && (line_pol ? $fell(line_level) : $rose(line_level))
      |=> edge_count == PHS_TRAIL_W'(PHS_CNT_START);
  endproperty
  a_measured_edge: assert property (p_measured_edge)
    else $error("Counter not restarted by the corrected line sync rise.");

  property p_lead_pos;
    $rose(edge_pulse) && $past(src) && $stable(timing1_ff)
      |-> edge_count == lead_pos + PHS_TRAIL_W'(PHS_CNT_START);
  endproperty
  a_lead_pos: assert property (p_lead_pos)
    else $error("Leading edge at the wrong distance from the rise.");

  // The counter stops at its top value, so the longest trailing code ends the pulse there.
  property p_trail_pos;
    $fell(edge_pulse) && $past(src) && !$past(line_rise) && $stable(timing1_ff)
      |-> edge_count == ((trail_code == '1) ? trail_code
                                            : trail_code + PHS_TRAIL_W'(PHS_CNT_START));
  endproperty
  a_trail_pos: assert property (p_trail_pos)
    else $error("Trailing edge at the wrong distance from the rise.");

  property p_src_gate;
    !src |=> !edge_pulse && edge_count == '0;
  endproperty
  a_src_gate: assert property (p_src_gate)
    else $error("Edge logic active while pass-through is selected.");

  property p_no_pulse;
    lead_pos >= trail_code |=> !edge_pulse;
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("Pulse emitted for a zero or negative length.");

  property p_default_none;
    trail_code == '0 |=> !edge_pulse;
  endproperty
  a_default_none: assert property (p_default_none)
    else $error("Pulse emitted with trailing code zero.");

  // A write's access phase still shows the last word read, so only reads are checked.
  property p_reserved_zero;
    psel_in && penable_in && !pwrite_in && paddr_in == PHS_TIMING1_ADDR
      |-> (prdata_out & ~PHS_TIMING1_MASK) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved timing bits read non-zero.");

  property p_count_run;
    s_int_rise ##1 s_quiet3 |=> edge_count == PHS_TRAIL_W'(4);
  endproperty
  a_count_run: assert property (p_count_run)
    else $error("Edge counter does not advance one per clock.");

  property p_write_lands;
    psel_in && penable_in && pwrite_in && paddr_in == PHS_TIMING1_ADDR && pstrb_in == '1
      |=> timing1_ff == ($past(pwdata_in) & PHS_TIMING1_MASK);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Full-word timing write did not land with reserved bits cleared.");

  // An unmapped access must leave every register as it was, writes included.
  property p_unmapped_ignored;
    psel_in && penable_in && !rd_hit |=> $stable(timing1_ff) && $stable(timing2_ff);
  endproperty
  a_unmapped_ignored: assert property (p_unmapped_ignored)
    else $error("Access to an unmapped address changed a register.");
endmodule
`default_nettype wire

// >>> include/phs_pkg.sv
// Register map, field layout and timing constants of the panel line sync generator.
package phs_pkg;
  // Register bus.
  localparam int unsigned PHS_ADDR_W        = 12;
  localparam int unsigned PHS_DATA_W        = 32;
  localparam int unsigned PHS_STRB_W        = 4;
  localparam logic [11:0] PHS_TIMING1_ADDR  = 12'h400;
  localparam logic [11:0] PHS_TIMING2_ADDR  = 12'h404;
  localparam logic [11:0] PHS_STATUS_ADDR   = 12'h408;
  // First panel timing register layout.
  localparam int unsigned PHS_FRAME_POL_BIT = 30;
  localparam int unsigned PHS_LINE_POL_BIT  = 29;
  localparam int unsigned PHS_SRC_BIT       = 27;
  localparam int unsigned PHS_LCOUNT_HI     = 26;
  localparam int unsigned PHS_LCOUNT_LO     = 16;
  localparam int unsigned PHS_LEAD_HI       = 7;
  localparam int unsigned PHS_LEAD_LO       = 5;
  localparam int unsigned PHS_TRAIL_HI      = 4;
  localparam int unsigned PHS_TRAIL_LO      = 0;
  localparam int unsigned PHS_LEAD_W        = 3;
  localparam int unsigned PHS_TRAIL_W       = 5;
  localparam int unsigned PHS_LCOUNT_W      = 11;
  localparam logic [31:0] PHS_TIMING1_MASK  = 32'h6fff_00ff;
  localparam logic [31:0] PHS_TIMING1_RESET = 32'h0000_0000;
  // Second panel timing register: only the output line sync polarity is kept.
  localparam int unsigned PHS_OUT_POL_BIT   = 22;
  localparam logic [31:0] PHS_TIMING2_MASK  = 32'h0040_0000;
  localparam logic [31:0] PHS_TIMING2_RESET = 32'h0000_0000;
  // Status register layout.
  localparam int unsigned PHS_ST_LINE_BIT   = 0;
  localparam int unsigned PHS_ST_FRAME_BIT  = 1;
  localparam int unsigned PHS_ST_PULSE_BIT  = 2;
  localparam int unsigned PHS_ST_SRC_BIT    = 3;
  localparam int unsigned PHS_ST_CNT_LO     = 8;
  // Edge timing: a non-zero leading code N places the edge N+1 clocks after the rise.
  localparam logic [2:0]  PHS_LEAD_NO_DELAY = 3'h0;
  localparam int unsigned PHS_LEAD_STEP     = 1;
  localparam int unsigned PHS_CNT_START     = 1;
endpackage

// >>> rtl/phs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter on the last two stages.
`timescale 1ns/1ps
`default_nettype none
module phs_pin_sync
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // Asynchronous pin
  input  wire logic pin_in,
  // Filtered level
  output logic      level_out
);
  logic meta_ff;
  logic mid_ff;
  logic last_ff;
  logic level_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      meta_ff <= 1'b0;
      mid_ff  <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      mid_ff  <= meta_ff;
      last_ff <= mid_ff;
    end
  end

  // A change is accepted only once two settled stages agree.
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      level_ff <= 1'b0;
    else if (mid_ff == last_ff)
      level_ff <= last_ff;
  end

  assign level_out = level_ff;
endmodule
`default_nettype wire

// >>> rtl/phs_edge_gen.sv
// Delay counter that places the generated line sync pulse after each input rise.
`timescale 1ns/1ps
`default_nettype none
module phs_edge_gen
#(
  parameter int unsigned CNT_W = phs_pkg::PHS_TRAIL_W
)
(
  // Clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        reset_in,
  // Control
  input  wire logic                        enable_in,
  input  wire logic                        rise_in,
  input  wire logic [phs_pkg::PHS_LEAD_W-1:0] lead_in,
  input  wire logic [CNT_W-1:0]            trail_in,
  // Result
  output logic                             pulse_out,
  output logic [CNT_W-1:0]                 count_out
);
  import phs_pkg::*;

  if (CNT_W < PHS_TRAIL_W)
  begin : g_bad_width
    $error("Counter narrower than the trailing edge field.");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  logic [CNT_W-1:0] cnt_ff;
  logic             run_ff;
  logic             pulse_ff;
  logic [CNT_W-1:0] pos;
  logic [CNT_W-1:0] lead_pos;
  logic             active;

  // Edges compare against the clocks elapsed since the rise; a lead past the trail gives none.
  always_comb
  begin
    pos      = rise_in ? '0 : cnt_ff;
    lead_pos = (lead_in == PHS_LEAD_NO_DELAY) ? '0
             : CNT_W'(lead_in) + CNT_W'(PHS_LEAD_STEP);
    active   = (rise_in || run_ff) && (pos >= lead_pos) && (pos < trail_in)
             && (lead_pos < trail_in);
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !enable_in)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end
    else if (rise_in)
    begin
      cnt_ff <= CNT_W'(PHS_CNT_START);
      run_ff <= 1'b1;
    end
    else if (run_ff && cnt_ff != CNT_MAX)
      cnt_ff <= cnt_ff + CNT_W'(PHS_CNT_START);
    else
      run_ff <= 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || !enable_in)
      pulse_ff <= 1'b0;
    else
      pulse_ff <= active;
  end

  assign pulse_out = pulse_ff;
  assign count_out = cnt_ff;
endmodule
`default_nettype wire

// >>> verif/phs_sync_source.sv
// Behavioural pixel source that drives the line and frame sync pins of the generator.
`timescale 1ns/1ps
`default_nettype none
module phs_sync_source
(
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_in,
  // Line pulse request
  input  wire logic       line_go_in,
  input  wire logic [5:0] line_width_in,
  input  wire logic       line_idle_high_in,
  // Frame level request
  input  wire logic       frame_active_in,
  input  wire logic       frame_idle_high_in,
  // Sync pins
  output logic            line_pin_out,
  output logic            frame_pin_out
);
  logic [5:0] left_ff;
  logic       line_act_ff;
  logic       frame_pin_ff;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      left_ff     <= 6'h00;
      line_act_ff <= 1'b0;
    end
    else if (line_go_in)
    begin
      left_ff     <= line_width_in - 6'h01;
      line_act_ff <= 1'b1;
    end
    else if (left_ff != 6'h00)
      left_ff <= left_ff - 6'h01;
    else
      line_act_ff <= 1'b0;
  end

  // The whole waveform flips with the idle level, so a low-idle source pulses high.
  assign line_pin_out = line_act_ff ^ line_idle_high_in;

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      frame_pin_ff <= 1'b0;
    else
      frame_pin_ff <= frame_active_in ^ frame_idle_high_in;
  end

  assign frame_pin_out = frame_pin_ff;
endmodule
`default_nettype wire

// >>> verif/tb_phs_line_sync_gen.sv
// Self-checking bench for the panel line sync generator and its timing registers.
`timescale 1ns/1ps
`default_nettype none
module tb_phs_line_sync_gen;
  import phs_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lout;
  logic        fout;
  logic [10:0] lcnt;
  logic        go = 1'b0;
  logic [5:0]  gw = 6'h04;
  logic        lih = 1'b0;
  logic        fact = 1'b0;
  logic        fih = 1'b0;
  logic        lpin;
  logic        fpin;
  int          bad_count = 0;
  int          n_compared = 0;

  always #12.5 clk = ~clk;

  phs_line_sync_gen dut (.sys_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .source_line_sync_in(lpin), .source_frame_sync_in(fpin),
    .line_pulse_or_sync_out(lout), .frame_sync_active_out(fout),
    .panel_line_count_out(lcnt));

  phs_sync_source src_model (.sys_clk_in(clk), .reset_in(rst), .line_go_in(go),
    .line_width_in(gw), .line_idle_high_in(lih), .frame_active_in(fact),
    .frame_idle_high_in(fih), .line_pin_out(lpin), .frame_pin_out(fpin));

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns one edge after release so psel idles a cycle.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    chk("access cycles", 32'd1, n);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] cfg(input logic p30, input logic p29, input logic src,
                                      input logic [10:0] lc, input logic [2:0] ld,
                                      input logic [4:0] tr);
    return {1'b0, p30, p29, 1'b0, src, lc, 8'h00, ld, tr};
  endfunction

  // Fires one source pulse; cycle 0 is the first cycle with the pin active.
  task automatic line_run(input logic act, output int first, output int len);
    int n;
    first = 0;
    len = 0;
    chk("line idle", {31'h0, ~act}, {31'h0, lout});
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 1; n < 49; n++)
    begin
      @(posedge clk);
      #1;
      if (lout === act)
      begin
        if (first == 0)
          first = n;
        len++;
      end
    end
    @(posedge clk);
  endtask

  initial
  begin
    #250000;
    bad_count++;
    final_report();
  end

  initial
  begin
    logic [31:0] rdat;
    logic        err;
    logic [2:0]  lt [8] = '{3'h0, 3'h1, 3'h7, 3'h3, 3'h0, 3'h1, 3'h1, 3'h0};
    logic [4:0]  tt [8] = '{5'h04, 5'h04, 5'h1f, 5'h04, 5'h00, 5'h04, 5'h04, 5'h01};
    logic [7:0]  p22m = 8'h20;
    logic [7:0]  p29m = 8'h40;
    int          i;
    int          el;
    int          ln;
    int          first;
    int          len;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(1'b0, PHS_TIMING1_ADDR, 32'h0, 4'hf, rdat, err);
    chk("timing1 reset", 32'h0000_0000, rdat);
    xfer(1'b0, PHS_TIMING2_ADDR, 32'h0, 4'hf, rdat, err);
    chk("timing2 reset", 32'h0000_0000, rdat);
    xfer(1'b1, PHS_TIMING2_ADDR, 32'hffff_ffff, 4'hf, rdat, err);
    xfer(1'b0, PHS_TIMING2_ADDR, 32'h0, 4'hf, rdat, err);
    chk("timing2 mask", 32'h0040_0000, rdat);
    xfer(1'b1, PHS_TIMING1_ADDR, 32'hffff_ffff, 4'hf, rdat, err);
    xfer(1'b0, PHS_TIMING1_ADDR, 32'h0, 4'hf, rdat, err);
    chk("timing1 reserved", 32'h6fff_00ff, rdat);
    chk("line count", 32'h0000_07ff, {21'h0, lcnt});
    xfer(1'b1, PHS_TIMING1_ADDR, 32'h01e0_0000, 4'hc, rdat, err);
    xfer(1'b0, PHS_TIMING1_ADDR, 32'h0, 4'hf, rdat, err);
    chk("timing1 lanes", 32'h01e0_00ff, rdat);
    chk("line count", 32'h0000_01e0, {21'h0, lcnt});
    xfer(1'b1, 12'h40c, 32'hffff_ffff, 4'hf, rdat, err);
    chk("unmapped write err", 32'h0000_0001, {31'h0, err});
    xfer(1'b0, 12'h40c, 32'h0, 4'hf, rdat, err);
    chk("unmapped read err", 32'h0000_0001, {31'h0, err});
    chk("unmapped read data", 32'h0000_0000, rdat);
    for (i = 0; i < 2; i++)
    begin
      xfer(1'b1, PHS_TIMING1_ADDR, cfg(1'b0, 1'b0, 1'b0, 11'h000, 3'h1, (i == 0) ? 5'h04 : 5'h00),
           4'hf, rdat, err);
      repeat (40) @(posedge clk);
      line_run(1'b1, first, len);
      chk("pass start", 32'd5, first);
      chk("pass width", 32'd4, len);
    end
    for (i = 0; i < 8; i++)
    begin
      xfer(1'b1, PHS_TIMING2_ADDR, {9'h0, p22m[i], 22'h0}, 4'hf, rdat, err);
      xfer(1'b1, PHS_TIMING1_ADDR, cfg(1'b0, p29m[i], 1'b1, 11'h000, lt[i], tt[i]),
           4'hf, rdat, err);
      lih <= p29m[i];
      repeat (40) @(posedge clk);
      el = (lt[i] == 3'h0) ? 0 : lt[i] + 1;
      ln = (tt[i] > el) ? tt[i] - el : 0;
      line_run(~p22m[i], first, len);
      chk("gen start", (ln == 0) ? 0 : 6 + el, first);
      chk("gen width", ln, len);
    end
    for (i = 0; i < 2; i++)
    begin
      xfer(1'b1, PHS_TIMING1_ADDR, cfg(i[0], 1'b0, 1'b0, 11'h000, 3'h0, 5'h00),
           4'hf, rdat, err);
      fih <= i[0];
      fact <= 1'b1;
      repeat (8) @(posedge clk);
      chk("frame active", 32'h0000_0001, {31'h0, fout});
      xfer(1'b0, PHS_STATUS_ADDR, 32'h0, 4'hf, rdat, err);
      chk("status frame", 32'h0000_0002, rdat);
      fact <= 1'b0;
      repeat (8) @(posedge clk);
      chk("frame idle", 32'h0000_0000, {31'h0, fout});
    end
    final_report();
  end
endmodule
`default_nettype wire
